/* File: src/qpad_consts.vh */
// Constants for the quad-port serial address decoder
// What this block does
// RULE1: Primary address: high strap, 1, 0, low straps
// RULE2: Also accept broadcast address 0110000b
// RULE3: Answer alert response address while interrupt active
// RULE4: Three quads, each at its own address
// RULE5: Quads at base, base+1, base+2 addresses
// RULE6: Ignore addresses whose bits 5:4 differ from 10
// RULE7: Global register writes reach all three quads
// RULE8: Enabled port events drive active-low interrupt
// RULE9: Host uses alert response to find interrupter
// RULE10: Joined data pins act as one open-drain line
// RULE11: Slave only, interrupt on its own pin
// RULE12: Quad index is address minus base address
`ifndef QPAD_CONSTS_VH
`define QPAD_CONSTS_VH

// Address fields
`define QPAD_FIX_HI          5
`define QPAD_FIX_LO          4
`define QPAD_FIX_VAL         2'h2
`define QPAD_BCAST_ADDR      7'h30
`define QPAD_ARA_ADDR        7'h0c
`define QPAD_NUM_QUADS       3
`define QPAD_PORTS           12

// Global registers, written to every quad
`define QPAD_REG_CHIP_RESET  8'h1a
`define QPAD_REG_SHDN_POL    8'h27
`define QPAD_REG_GPIO        8'h41

// Byte kinds within one transfer
`define QPAD_KIND_ADDR       2'h0
`define QPAD_KIND_PTR        2'h1
`define QPAD_KIND_DATA       2'h2

// Bit counter limit and synchroniser width
`define QPAD_LAST_BIT        3'h7
`define QPAD_SYNC_W          7

`endif

/* File: src/qpad_sync.v */
// Two-stage synchroniser for pins entering the system clock domain
`timescale 1ns/1ns
module qpad_sync #(
   parameter W = 1
) (
   input  wire         clk_i,
   input  wire         rst_i,
   input  wire [W-1:0] d_i,
   output wire [W-1:0] q_o
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   // First stage feeds only the second; idle bus level is high
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= {W{1'b1}};
         sync_q <= {W{1'b1}};
      end else begin
         meta_q <= d_i;
         sync_q <= meta_q;
      end
   end

   assign q_o = sync_q;
endmodule // qpad_sync

/* File: src/qpad_top.v */
// Serial bus slave: quad address decode, register access steering, alert line
`timescale 1ns/1ns
`include "qpad_consts.vh"
module qpad_top (
   input  wire        CLK_SYS_I,
   input  wire        RESET_I,
   input  wire        SCL_I,
   input  wire        SERIAL_DATA_INPUT_PIN_I,
   output wire        SERIAL_DATA_OUTPUT_PIN_O,
   output wire        SERIAL_DATA_OUTPUT_PIN_OE_N_O,
   input  wire        HIGH_ADDRESS_STRAP_I,
   input  wire [3:0]  LOW_ADDRESS_STRAPS_I,
   input  wire [11:0] PORT_EVENT_I,
   input  wire [11:0] EVENT_ENABLE_I,
   output wire        INT_N_O,
   output wire        INT_N_OE_N_O,
   output reg         WR_STROBE_O,
   output reg  [2:0]  WR_QUAD_O,
   output reg  [7:0]  WR_ADDR_O,
   output reg  [7:0]  WR_DATA_O,
   output wire        RD_REQ_O,
   output reg  [2:0]  RD_QUAD_O,
   output reg  [7:0]  RD_ADDR_O,
   input  wire [7:0]  RD_DATA_I
);
   // One-hot states
   localparam [4:0] S_IDLE = 5'h01;
   localparam [4:0] S_RX   = 5'h02;
   localparam [4:0] S_ACK  = 5'h04;
   localparam [4:0] S_TX   = 5'h08;
   localparam [4:0] S_RACK = 5'h10;

   wire [6:0] pins_s;
   reg        scl_d_q;
   reg        sda_d_q;
   reg [4:0]  state_q;
   reg [2:0]  bit_cnt_q;
   reg [7:0]  shift_q;
   reg [1:0]  kind_q;
   reg        rw_q;
   reg        bcast_q;
   reg        ara_q;
   reg        ack_pend_q;
   reg        byte_done_q;
   reg        sda_drv_q;
   reg [2:0]  quad_sel_q;
   reg [7:0]  ptr_q;
   reg [6:0]  base_q;
   reg        strap_cap_q;
   reg [1:0]  strap_wait_q;
   reg        rd_cap_q;
   reg [7:0]  rd_data_q;
   reg        alert_q;
   reg [11:0] ev_prev_q;
   reg [2:0]  match;
   integer    k;

   // Pins pass two flops before any logic reads them
   qpad_sync #(
      .W (`QPAD_SYNC_W)
   ) u_sync (
      .clk_i (CLK_SYS_I),
      .rst_i (RESET_I),
      .d_i   ({SCL_I, SERIAL_DATA_INPUT_PIN_I, HIGH_ADDRESS_STRAP_I, LOW_ADDRESS_STRAPS_I}),
      .q_o   (pins_s)
   );

   wire scl_s = pins_s[6];
   wire sda_s = pins_s[5];

   // Bus edge and condition detection on synchronised levels
   wire scl_rise  = scl_s & ~scl_d_q;
   wire scl_fall  = ~scl_s & scl_d_q;
   wire start_det = scl_s & scl_d_q & sda_d_q & ~sda_s;
   wire stop_det  = scl_s & scl_d_q & ~sda_d_q & sda_s;
   wire [7:0] rx_byte = {shift_q[6:0], sda_s};
   wire [6:0] rx_addr = rx_byte[7:1];

   // Global registers are shared by every quad
   function is_global;
      input [7:0] ptr;
      begin
         is_global = (ptr == `QPAD_REG_CHIP_RESET) || (ptr == `QPAD_REG_SHDN_POL) ||
                     (ptr == `QPAD_REG_GPIO);
      end
   endfunction

   // Quad k answers at base plus k, only inside the legal x10xxxx range
   always @* begin
      match = 3'h0;
      for (k = 0; k < `QPAD_NUM_QUADS; k = k + 1)
         match[k] = (rx_addr == base_q + k[6:0]) &&                  // RULE4 RULE5 RULE12
                    (rx_addr[`QPAD_FIX_HI:`QPAD_FIX_LO] == `QPAD_FIX_VAL); // RULE6
   end

   wire bcast_hit = (rx_addr == `QPAD_BCAST_ADDR) & ~rx_byte[0];     // RULE2
   wire ara_hit   = (rx_addr == `QPAD_ARA_ADDR) & rx_byte[0] & alert_q; // RULE3
   wire addr_hit  = (|match) | bcast_hit | ara_hit;

   // Straps caught once, after the synchroniser has flushed its reset ones
   always @(posedge CLK_SYS_I or posedge RESET_I) begin
      if (RESET_I) begin
         base_q       <= 7'h00;
         strap_cap_q  <= 1'b0;
         strap_wait_q <= 2'h0;
      end else begin
         strap_wait_q <= {strap_wait_q[0], 1'b1};
         if (strap_wait_q[1] && !strap_cap_q) begin
            base_q      <= {pins_s[4], `QPAD_FIX_VAL, pins_s[3:0]}; // RULE1
            strap_cap_q <= 1'b1;
         end
      end
   end

   // Read request when the master wants the next byte
   assign RD_REQ_O = scl_rise & ~ara_q &
                     ((state_q == S_RX && bit_cnt_q == `QPAD_LAST_BIT && kind_q ==
                       `QPAD_KIND_ADDR && rx_byte[0] && (|match)) ||
                      (state_q == S_RACK && !sda_s));

   // Slave protocol engine; never drives the clock, only pulls data low
   always @(posedge CLK_SYS_I or posedge RESET_I) begin
      if (RESET_I) begin
         scl_d_q     <= 1'b1;
         sda_d_q     <= 1'b1;
         state_q     <= S_IDLE;
         bit_cnt_q   <= 3'h0;
         shift_q     <= 8'h00;
         kind_q      <= `QPAD_KIND_ADDR;
         rw_q        <= 1'b0;
         bcast_q     <= 1'b0;
         ara_q       <= 1'b0;
         ack_pend_q  <= 1'b0;
         byte_done_q <= 1'b0;
         sda_drv_q   <= 1'b0;
         quad_sel_q  <= 3'h0;
         ptr_q       <= 8'h00;
         WR_STROBE_O <= 1'b0;
         WR_QUAD_O   <= 3'h0;
         WR_ADDR_O   <= 8'h00;
         WR_DATA_O   <= 8'h00;
         RD_QUAD_O   <= 3'h0;
         RD_ADDR_O   <= 8'h00;
      end else begin
         scl_d_q     <= scl_s;
         sda_d_q     <= sda_s;
         WR_STROBE_O <= 1'b0;
         if (RD_REQ_O) begin
            RD_QUAD_O <= (state_q == S_RX) ? match : quad_sel_q;
            RD_ADDR_O <= (state_q == S_RX) ? ptr_q : ptr_q + 8'h01;
         end
         if (start_det) begin
            // Repeated start restarts address reception
            state_q     <= S_RX;
            bit_cnt_q   <= 3'h0;
            kind_q      <= `QPAD_KIND_ADDR;
            byte_done_q <= 1'b0;
            sda_drv_q   <= 1'b0;
            ara_q       <= 1'b0; // Stale alert flag would block read requests
         end else if (stop_det) begin
            state_q   <= S_IDLE;
            sda_drv_q <= 1'b0;
         end else begin
            case (state_q)
               S_IDLE: begin
                  sda_drv_q <= 1'b0;
               end
               S_RX: begin
                  if (scl_rise) begin
                     shift_q     <= rx_byte;
                     bit_cnt_q   <= bit_cnt_q + 3'h1;
                     byte_done_q <= (bit_cnt_q == `QPAD_LAST_BIT);
                     if (bit_cnt_q == `QPAD_LAST_BIT) begin
                        if (kind_q == `QPAD_KIND_ADDR) begin
                           ack_pend_q <= addr_hit & ~(rx_byte[0] & (|match) == 1'b0 &
                                         ~ara_hit);
                           rw_q       <= rx_byte[0];
                           bcast_q    <= bcast_hit;
                           ara_q      <= ara_hit;
                           quad_sel_q <= match;
                           kind_q     <= `QPAD_KIND_PTR;
                        end else if (kind_q == `QPAD_KIND_PTR) begin
                           ack_pend_q <= 1'b1;
                           ptr_q      <= rx_byte;
                           kind_q     <= `QPAD_KIND_DATA;
                        end else begin
                           // Global writes fan out to all quads
                           ack_pend_q  <= 1'b1;
                           WR_STROBE_O <= 1'b1;
                           WR_QUAD_O   <= (bcast_q | is_global(ptr_q)) ? 3'h7 :
                                          quad_sel_q; // RULE7 RULE12
                           WR_ADDR_O   <= ptr_q;
                           WR_DATA_O   <= rx_byte;
                           ptr_q       <= ptr_q + 8'h01;
                        end
                     end
                  end else if (scl_fall && byte_done_q) begin
                     byte_done_q <= 1'b0;
                     if (ack_pend_q) begin
                        sda_drv_q <= 1'b1; // RULE10
                        state_q   <= S_ACK;
                     end else begin
                        state_q <= S_IDLE; // RULE6
                     end
                  end
               end
               S_ACK: begin
                  if (scl_fall) begin
                     if (rw_q && kind_q == `QPAD_KIND_PTR) begin
                        // Read: first data bit follows the address acknowledge
                        sda_drv_q <= ara_q ? ~base_q[6] : ~rd_data_q[7];
                        shift_q   <= ara_q ? {base_q[5:0], 2'h0} : {rd_data_q[6:0], 1'b0};
                        bit_cnt_q <= 3'h0;
                        state_q   <= S_TX;
                     end else begin
                        sda_drv_q <= 1'b0;
                        bit_cnt_q <= 3'h0;
                        state_q   <= S_RX;
                     end
                  end
               end
               S_TX: begin
                  if (scl_rise && !sda_drv_q && !sda_s) begin
                     // Lost alert arbitration to a lower address
                     state_q <= S_IDLE;
                  end else if (scl_fall) begin
                     if (bit_cnt_q == `QPAD_LAST_BIT) begin
                        sda_drv_q <= 1'b0;
                        state_q   <= S_RACK;
                     end else begin
                        sda_drv_q <= ~shift_q[7];
                        shift_q   <= {shift_q[6:0], 1'b0};
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                     end
                  end
               end
               S_RACK: begin
                  if (scl_rise) begin
                     byte_done_q <= ~sda_s & ~ara_q;
                     if (!sda_s && !ara_q)
                        ptr_q <= ptr_q + 8'h01;
                  end else if (scl_fall) begin
                     if (byte_done_q) begin
                        // Master acked: stream the next register
                        sda_drv_q   <= ~rd_data_q[7];
                        shift_q     <= {rd_data_q[6:0], 1'b0};
                        bit_cnt_q   <= 3'h0;
                        byte_done_q <= 1'b0;
                        state_q     <= S_TX;
                     end else begin
                        state_q <= S_IDLE;
                     end
                  end
               end
               default: begin
                  state_q   <= S_IDLE;
                  sda_drv_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // Read data captured one cycle after the request
   always @(posedge CLK_SYS_I or posedge RESET_I) begin
      if (RESET_I) begin
         rd_cap_q  <= 1'b0;
         rd_data_q <= 8'h00;
      end else begin
         rd_cap_q <= RD_REQ_O;
         if (rd_cap_q)
            rd_data_q <= RD_DATA_I;
      end
   end

   // Alert: new enabled event raises it, a won alert response clears it
   wire [11:0] ev_on   = PORT_EVENT_I & EVENT_ENABLE_I;
   wire        ev_new  = |(ev_on & ~ev_prev_q);
   wire        ara_won = (state_q == S_TX) & ara_q & scl_fall &
                         (bit_cnt_q == `QPAD_LAST_BIT);
   always @(posedge CLK_SYS_I or posedge RESET_I) begin
      if (RESET_I) begin
         alert_q   <= 1'b0;
         ev_prev_q <= 12'h000;
      end else begin
         ev_prev_q <= ev_on;
         if (ev_new)
            alert_q <= 1'b1; // RULE8
         else if (ara_won || ev_on == 12'h000)
            alert_q <= 1'b0; // RULE3
      end
   end

   // Open-drain pins: output low, enable low while pulling
   assign SERIAL_DATA_OUTPUT_PIN_O      = 1'b0;
   assign SERIAL_DATA_OUTPUT_PIN_OE_N_O = ~sda_drv_q; // RULE10 RULE11
   assign INT_N_O                       = 1'b0;
   assign INT_N_OE_N_O                  = ~alert_q;   // RULE8 RULE11
endmodule // qpad_top

/* File: dv/qpad_top_chk.sv */
// Checker on the ports of the quad address decoder
`timescale 1ns/1ns
module qpad_chk (
   input wire        CLK_SYS_I,
   input wire        RESET_I,
   input wire        SCL_I,
   input wire        SERIAL_DATA_INPUT_PIN_I,
   input wire        SERIAL_DATA_OUTPUT_PIN_O,
   input wire        SERIAL_DATA_OUTPUT_PIN_OE_N_O,
   input wire        HIGH_ADDRESS_STRAP_I,
   input wire [3:0]  LOW_ADDRESS_STRAPS_I,
   input wire [11:0] PORT_EVENT_I,
   input wire [11:0] EVENT_ENABLE_I,
   input wire        INT_N_O,
   input wire        INT_N_OE_N_O,
   input wire        WR_STROBE_O,
   input wire [2:0]  WR_QUAD_O,
   input wire [7:0]  WR_ADDR_O,
   input wire [7:0]  WR_DATA_O,
   input wire        RD_REQ_O,
   input wire [2:0]  RD_QUAD_O,
   input wire [7:0]  RD_ADDR_O,
   input wire [7:0]  RD_DATA_I
);
   wire [11:0] live = PORT_EVENT_I & EVENT_ENABLE_I;
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (RESET_I);
   // Enabled event appears, or stays absent
   sequence ev_rise; $rose(|live); endsequence
   sequence ev_quiet; (live == 12'h000) [*3]; endsequence
   int_set_a: assert property (ev_rise |-> ##[1:2] !INT_N_OE_N_O)
      else $error("interrupt not raised");
   int_clr_a: assert property (ev_quiet |-> ##[0:2] INT_N_OE_N_O)
      else $error("interrupt not released");
   wr_pulse_a: assert property (WR_STROBE_O |=> !WR_STROBE_O)
      else $error("write strobe too long");
   wr_quad_a: assert property (WR_STROBE_O |-> WR_QUAD_O inside {1, 2, 4, 7})
      else $error("bad write quad");
   wr_stand_a: assert property (!WR_STROBE_O |-> $stable({WR_ADDR_O, WR_DATA_O}))
      else $error("write fields moved");
   rd_pulse_a: assert property (RD_REQ_O |=> !RD_REQ_O)
      else $error("read request too long");
   rd_quad_a: assert property (RD_REQ_O |=> RD_QUAD_O inside {1, 2, 4})
      else $error("bad read quad");
   pin_low_a: assert property (!SERIAL_DATA_OUTPUT_PIN_O && !INT_N_O)
      else $error("open drain value not low");
endmodule // qpad_chk
bind qpad_top qpad_chk chk (.*);

/* File: dv/qpad_host.sv */
// Bus master model: serial clock and open-drain data
`timescale 1ns/1ns
module qpad_host (
   input  wire clk_i,
   input  wire sda_i,
   output reg  scl_o,
   output reg  sda_oe_n_o
);
   initial begin
      scl_o = 1'b1;
      sda_oe_n_o = 1'b1;
   end
   // Quarter link period; clock stands high between frames
   task q;
      repeat (2) @(posedge clk_i);
   endtask
   // Start or repeated start
   task start;
      sda_oe_n_o <= 1'b1;
      q;
      scl_o <= 1'b1;
      q;
      sda_oe_n_o <= 1'b0;
      q;
      scl_o <= 1'b0;
      q;
   endtask
   task stop;
      sda_oe_n_o <= 1'b0;
      q;
      scl_o <= 1'b1;
      q;
      sda_oe_n_o <= 1'b1;
      q;
   endtask
   // Data set while clock low, sampled while high
   task bitx(input b, output r);
      sda_oe_n_o <= b;
      q;
      scl_o <= 1'b1;
      q;
      r = sda_i;
      q;
      scl_o <= 1'b0;
      q;
   endtask
   // Eight bits MSB first, then the ninth
   task xfer(input [7:0] d, input nine, output [7:0] r, output ack);
      reg a;
      integer i;
      for (i = 7; i >= 0; i = i - 1) bitx(d[i], r[i]);
      bitx(nine, a);
      ack = ~a;
   endtask
endmodule // qpad_host

/* File: dv/qpad_tb.sv */
// Self-checking bench for the quad address decoder
`timescale 1ns/1ns
`include "qpad_consts.vh"
module testbench;
   reg         clk = 1'b0;
   reg         rst = 1'b1;
   reg  [6:0]  b = 7'h20;
   reg  [11:0] ev = 12'h000;
   reg  [11:0] en = 12'h000;
   wire        sda, scl, h_oe_n, d_oe_n, ws, rq, int_oe_n;
   wire [2:0]  wq, rqd;
   wire [7:0]  wa, wd, ra;
   // Quad register file stand-in, stable while addressed
   wire [7:0]  rdat = {ra[4:0], rqd} ^ 8'h5a;
   reg  [18:0] wlog[$];
   reg  [31:0] seed;
   reg  [6:0]  a;
   reg  [7:0]  p, r;
   reg  [11:0] m;
   reg         ack;
   integer     t, k, fail_count = 0, checked = 0, cyc = 0;
   // Pull-up on the joined data pins
   assign sda = h_oe_n & d_oe_n;
   initial forever #50 clk = ~clk;
   qpad_host host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_n_o(h_oe_n));
   qpad_top dut (.CLK_SYS_I(clk), .RESET_I(rst), .SCL_I(scl),
      .SERIAL_DATA_INPUT_PIN_I(sda), .SERIAL_DATA_OUTPUT_PIN_O(),
      .SERIAL_DATA_OUTPUT_PIN_OE_N_O(d_oe_n), .HIGH_ADDRESS_STRAP_I(b[6]),
      .LOW_ADDRESS_STRAPS_I(b[3:0]), .PORT_EVENT_I(ev), .EVENT_ENABLE_I(en),
      .INT_N_O(), .INT_N_OE_N_O(int_oe_n), .WR_STROBE_O(ws), .WR_QUAD_O(wq),
      .WR_ADDR_O(wa), .WR_DATA_O(wd), .RD_REQ_O(rq), .RD_QUAD_O(rqd),
      .RD_ADDR_O(ra), .RD_DATA_I(rdat));
   // Log every register write; a hang is cut short
   always @(posedge clk) begin
      if (ws === 1'b1) wlog.push_back({wq, wa, wd});
      cyc = cyc + 1;
      if (cyc == 40000) begin
         fail_count = fail_count + 1;
         close_out;
      end
   end
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function glob(input [7:0] x);
      glob = x == `QPAD_REG_CHIP_RESET || x == `QPAD_REG_SHDN_POL || x == `QPAD_REG_GPIO;
   endfunction
   task chk(input [31:0] g, input [31:0] e);
      checked = checked + 1;
      if (g !== e) begin
         fail_count = fail_count + 1;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Pointer then two data bytes; global pointers or broadcast reach all quads
   task wr(input [6:0] ad, input [7:0] pt, input [7:0] d, input ok, input [2:0] qd);
      reg [7:0] x;
      reg ak;
      reg [2:0] eq;
      host.start;
      host.xfer({ad, 1'b0}, 1'b1, x, ak);
      chk(ak, ok);
      if (ak) begin
         host.xfer(pt, 1'b1, x, ak);
         host.xfer(d, 1'b1, x, ak);
         host.xfer(~d, 1'b1, x, ak);
      end
      host.stop;
      chk(wlog.size(), ok ? 2 : 0);
      while (wlog.size() > 0) begin
         eq = (glob(pt) || ad == `QPAD_BCAST_ADDR) ? 3'h7 : qd;
         chk(wlog.pop_front(), {eq, pt, d});
         pt = pt + 1;
         d = ~d;
      end
   endtask
   // Set pointer, repeated start, read two bytes
   task rd(input [6:0] ad, input [7:0] pt, input [2:0] qd);
      reg [7:0] x;
      reg ak;
      host.start;
      host.xfer({ad, 1'b0}, 1'b1, x, ak);
      host.xfer(pt, 1'b1, x, ak);
      host.start;
      host.xfer({ad, 1'b1}, 1'b1, x, ak);
      chk(ak, qd != 3'h0);
      if (ak) begin
         host.xfer(8'hff, 1'b0, x, ak);
         chk(x, {pt[4:0], qd} ^ 8'h5a);
         host.xfer(8'hff, 1'b1, x, ak);
         chk(x, {pt[4:0] + 5'h01, qd} ^ 8'h5a);
      end
      host.stop;
   endtask
   task close_out;
      if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Per strap setting: quads, broadcast, illegal, read, alert
   initial begin
      seed = 32'd71404;
      for (t = 0; t < 4; t = t + 1) begin
         seed = lfsr(seed);
         rst <= 1'b1;
         b <= t == 0 ? 7'h2f : t == 1 ? 7'h6e : {seed[4], 2'b10, seed[3:0]};
         repeat (4) @(posedge clk);
         rst <= 1'b0;
         repeat (6) @(posedge clk);
         for (k = 0; k < 4; k = k + 1) begin
            a = b + k;
            p = (t + k) % 4 == 0 ? seed[15:8] : (t + k) % 4 == 1 ? `QPAD_REG_CHIP_RESET
               : (t + k) % 4 == 2 ? `QPAD_REG_SHDN_POL : `QPAD_REG_GPIO;
            wr(a, p, seed[23:16], (k < 3 && a[5:4] == 2'b10) || a == `QPAD_BCAST_ADDR,
               3'h1 << k);
         end
         wr(`QPAD_BCAST_ADDR, seed[31:24], seed[7:0], 1'b1, 3'h7);
         wr(b ^ 7'h20, seed[31:24], seed[7:0], 1'b0, 3'h0);
         a = b + 1;
         rd(a, seed[31:24], a[5:4] == 2'b10 ? 3'h2 : 3'h0);
         rd(`QPAD_BCAST_ADDR, seed[15:8], 3'h0);
         // Masked event first, then enabled
         m = 12'h001 << (seed[7:0] % 12);
         ev <= m;
         en <= ~m;
         repeat (4) @(posedge clk);
         chk(int_oe_n, 1'b1);
         en <= m | seed[27:16];
         repeat (4) @(posedge clk);
         chk(int_oe_n, 1'b0);
         host.start;
         host.xfer({`QPAD_ARA_ADDR, 1'b1}, 1'b1, r, ack);
         chk(ack, 1'b1);
         host.xfer(8'hff, 1'b1, r, ack);
         chk(r, {b, 1'b0});
         host.stop;
         repeat (4) @(posedge clk);
         chk(int_oe_n, 1'b1);
         // Alert response address is ignored once the interrupt is gone
         host.start;
         host.xfer({`QPAD_ARA_ADDR, 1'b1}, 1'b1, r, ack);
         chk(ack, 1'b0);
         host.stop;
         ev <= 12'h000;
      end
      close_out;
   end
endmodule // testbench
